/* serial_eeprom_defs.svh */
// constants of the two-wire serial memory target
// assumes a 125 MHz system clock that samples the bus pins
`ifndef SERIAL_EEPROM_DEFS_SVH
`define SERIAL_EEPROM_DEFS_SVH

`define DEV_PREFIX 4'ha
`define MEM_BYTES 256
`define PAGE_BYTES 16
`define ERASED_BYTE 8'hff
`define ACK_BIT_CNT 4'h8
`define ACK_END_CNT 4'h9
`define LAST_DATA_CNT 4'h7
`define FIFO_DEPTH 8
`define PROG_TIME_US 5000
`define CLK_PERIOD_NS 8
`define PROG_CYCLES ((`PROG_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

/* serial_eeprom_pkg.sv */
// types shared by the serial memory target
// assumes nothing of its surroundings
package serial_eeprom_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_WADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } bus_state_t;

endpackage

/* word_fifo.sv */
// small synchronous fifo, flip-flop storage
// assumes both sides run on clk_sys
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data = mem_q[rd_ptr_q];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wr_ptr_q <= bump(wr_ptr_q);
            if (pop) rd_ptr_q <= bump(rd_ptr_q);
            if (push && !pop) count_q <= count_q + 1'b1;
            else if (pop && !push) count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* eeprom_array.sv */
// byte array with page latch and self-timed programming
// assumes writes of one page arrive before commit
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defs.svh"
module eeprom_array #(
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // page load stream, {address, data}
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // programming control
    input wire logic commit,
    input wire logic discard,
    output logic busy,
    // read port
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);
    localparam int TW = $clog2(PROG_CYCLES + 1);

    logic [7:0] mem_q [`MEM_BYTES];
    logic [7:0] page_q [`PAGE_BYTES];
    logic [`PAGE_BYTES-1:0] mask_q;
    logic [3:0] row_q;
    logic pend_q;
    logic busy_q;
    logic [TW-1:0] timer_q;

    // stalls the load while programming runs; a poll that lands in
    // programming discards nothing, the latched page must survive it
    assign wr_ready = !busy_q;
    assign busy = busy_q;
    assign rd_data = mem_q[rd_addr];

    wire take = wr_valid & wr_ready;
    // wait for the stream to drain so no byte is left behind
    wire start_prog = pend_q & !wr_valid & !busy_q;
    wire prog_done = busy_q & (timer_q == TW'(1));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            busy_q <= 1'b0;
            timer_q <= '0;
        end else begin
            if (start_prog) pend_q <= 1'b0;
            else if (commit && mask_q != '0) pend_q <= 1'b1;
            else if (discard) pend_q <= 1'b0;
            if (start_prog) begin
                busy_q <= 1'b1;
                timer_q <= TW'(PROG_CYCLES);
            end else if (busy_q) begin
                timer_q <= timer_q - 1'b1;
                if (prog_done) busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mask_q <= '0;
            row_q <= '0;
        end else if (prog_done || (discard && !pend_q && !busy_q)) begin
            mask_q <= '0;
        end else if (take) begin
            row_q <= wr_addr[7:4];
            mask_q[wr_addr[3:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (take) begin
            page_q[wr_addr[3:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `MEM_BYTES; i++) begin
                mem_q[i] <= `ERASED_BYTE;
            end
        end else begin
            for (int i = 0; i < `PAGE_BYTES; i++) begin
                if (mask_q[i] && start_prog) begin
                    mem_q[{row_q, 4'(i)}] <= `ERASED_BYTE;
                end else if (mask_q[i] && prog_done) begin
                    mem_q[{row_q, 4'(i)}] <= page_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* serial_eeprom_target.sv */
// two-wire serial memory target, bus front end and top level
// assumes SCL and SDA arrive asynchronously and are oversampled
// by clk_sys; SDA is open drain, pulled high outside the chip
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defs.svh"
module serial_eeprom_target
    import serial_eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = `PROG_CYCLES,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // strap pins, pulled low when open
    input wire logic chip_select_bit_hi,
    input wire logic chip_select_bit_mid,
    input wire logic chip_select_bit_lo,
    input wire logic write_lock,
    // status
    output logic standby,
    output logic prog_busy
);
    // pin order in the synchroniser
    localparam int P_SCL = 5;
    localparam int P_SDA = 4;
    localparam int P_LOCK = 0;

    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    bus_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] addr_q;
    logic sda_oe_q;
    logic sda_out_q;
    logic push_q;
    logic [15:0] push_word_q;
    logic loaded_q;
    logic commit_q;
    logic discard_q;
    logic standby_q;
    logic busy_q;
    logic prog_wait_q;

    logic fifo_ready;
    logic fifo_valid;
    logic [15:0] fifo_word;
    logic mem_ready;
    logic mem_busy;
    logic [7:0] rd_data;

    // every pin passes two flops before any logic reads it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 6'h30;
            sync_q <= 6'h30;
        end else begin
            meta_q <= {scl_in, sda_in, chip_select_bit_hi,
                       chip_select_bit_mid, chip_select_bit_lo,
                       write_lock};
            sync_q <= meta_q;
        end
    end

    wire scl_s = sync_q[P_SCL];
    wire sda_s = sync_q[P_SDA];
    // open straps read low, so a high level is a real drive
    wire [2:0] cs_pins = sync_q[3:1];
    wire lock_s = sync_q[P_LOCK] == 1'b1;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // bus conditions need SCL high on both samples
    wire scl_high = scl_s & scl_prev_q;
    wire start_cond = scl_high & sda_prev_q & ~sda_s;
    wire stop_cond = scl_high & ~sda_prev_q & sda_s;
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;

    wire active = state_q != ST_IDLE;
    wire data_bit = bit_cnt_q < `ACK_BIT_CNT;
    wire ack_phase = active & scl_fall & (bit_cnt_q == `ACK_BIT_CNT);
    wire ack_end = active & scl_fall & (bit_cnt_q == `ACK_END_CNT);
    wire host_ack_clk = scl_rise & (bit_cnt_q == `ACK_BIT_CNT);
    wire host_nack = host_ack_clk & (state_q == ST_RDATA) & sda_s;
    wire tx_bit = scl_fall & (state_q == ST_RDATA) & (bit_cnt_q != '0) &
                  (bit_cnt_q <= `LAST_DATA_CNT);

    // address byte: prefix, strap match, not busy programming
    wire prefix_ok = shift_q[7:4] == `DEV_PREFIX;
    wire strap_ok = shift_q[3:1] == cs_pins;
    wire dev_match = prefix_ok & strap_ok & ~mem_busy;
    wire rd_dir = shift_q[0];

    wire wr_room = fifo_ready & ~push_q;
    // reads never look at the lock
    wire commit_cond = stop_cond & (state_q == ST_WDATA) &
                       (loaded_q | push_q) & ~lock_s;

    function automatic bus_state_t after_byte(input bus_state_t s,
                                              input logic match,
                                              input logic rd);
        unique case (s)
            ST_DEV: after_byte = !match ? ST_IDLE :
                                 (rd ? ST_RDATA : ST_WADDR);
            ST_WADDR: after_byte = ST_WDATA;
            ST_WDATA: after_byte = ST_WDATA;
            ST_RDATA: after_byte = ST_RDATA;
            ST_IDLE: after_byte = ST_IDLE;
        endcase
    endfunction

    function automatic logic ack_for(input bus_state_t s,
                                     input logic match,
                                     input logic room);
        unique case (s)
            ST_DEV: ack_for = match;
            ST_WADDR: ack_for = 1'b1;
            ST_WDATA: ack_for = room;
            ST_RDATA: ack_for = 1'b0;
            ST_IDLE: ack_for = 1'b0;
        endcase
    endfunction

    // page write moves only the column, the row stays put
    function automatic logic [7:0] next_col(input logic [7:0] a);
        next_col = {a[7:4], a[3:0] + 4'h1};
    endfunction

    wire bus_state_t next_state = after_byte(state_q, dev_match, rd_dir);
    wire ack_drive = ack_for(state_q, dev_match, wr_room);

    // a start anywhere wins over any other decoding
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else if (start_cond) begin
            state_q <= ST_DEV;
        end else if (stop_cond || host_nack) begin
            state_q <= ST_IDLE;
        end else if (ack_phase) begin
            state_q <= next_state;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_q <= '0;
        end else if (start_cond || !active || ack_end) begin
            bit_cnt_q <= '0;
        end else if (scl_rise && bit_cnt_q != `ACK_END_CNT) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_q <= '0;
        end else if (start_cond) begin
            shift_q <= '0;
        end else if (active && scl_rise && data_bit) begin
            shift_q <= {shift_q[6:0], sda_s};
        end
    end

    // outgoing bits change only just after SCL falls
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sda_oe_q <= 1'b0;
        end else if (start_cond || stop_cond || host_nack) begin
            sda_oe_q <= 1'b0;
        end else if (ack_phase) begin
            sda_oe_q <= ack_drive;
        end else if (ack_end) begin
            sda_oe_q <= (state_q == ST_RDATA) & ~rd_data[7];
        end else if (tx_bit) begin
            sda_oe_q <= ~tx_q[7];
        end
    end

    // the pad level is never driven high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_q <= '0;
        end else if (ack_end && state_q == ST_RDATA) begin
            tx_q <= {rd_data[6:0], 1'b0};
        end else if (tx_bit) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // one counter serves writes and reads; it survives between commands
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (ack_phase && state_q == ST_WADDR) begin
            addr_q <= shift_q;
        end else if (ack_phase && state_q == ST_WDATA && wr_room) begin
            addr_q <= next_col(addr_q);
        end else if (ack_phase && state_q == ST_RDATA) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    // a full stream withholds the acknowledge instead of losing data
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            push_q <= 1'b0;
            push_word_q <= '0;
        end else begin
            push_q <= ack_phase & (state_q == ST_WDATA) & wr_room;
            push_word_q <= {addr_q, shift_q};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
        end else if (start_cond || stop_cond) begin
            loaded_q <= 1'b0;
        end else if (push_q) begin
            loaded_q <= 1'b1;
        end
    end

    // a stop after data programs; a start or a locked stop drops it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            commit_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            commit_q <= commit_cond;
            discard_q <= start_cond | (stop_cond & ~commit_cond);
        end
    end

    // the array needs two cycles from commit to busy; without this
    // standby would blink high in between and invite a new command
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prog_wait_q <= 1'b0;
        end else if (commit_q) begin
            prog_wait_q <= 1'b1;
        end else if (mem_busy || discard_q) begin
            prog_wait_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            standby_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            standby_q <= ~active & ~mem_busy & ~commit_q &
                         ~prog_wait_q;
            busy_q <= mem_busy;
        end
    end

    word_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(push_word_q),
        .out_valid(fifo_valid),
        .out_ready(mem_ready),
        .out_data(fifo_word)
    );

    eeprom_array #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_array (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_valid(fifo_valid),
        .wr_ready(mem_ready),
        .wr_addr(fifo_word[15:8]),
        .wr_data(fifo_word[7:0]),
        .commit(commit_q),
        .discard(discard_q),
        .busy(mem_busy),
        .rd_addr(addr_q),
        .rd_data(rd_data)
    );

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign standby = standby_q;
    assign prog_busy = busy_q;
endmodule
`default_nettype wire

/* serial_eeprom_target_asserts.sv */
// bus and status checks for the serial memory target
// assumes binding to the top level; all ports in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_target_asserts #(
    parameter int PROG_CYCLES = 50
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // straps and status
    input wire logic chip_select_bit_hi,
    input wire logic chip_select_bit_mid,
    input wire logic chip_select_bit_lo,
    input wire logic write_lock,
    input wire logic standby,
    input wire logic prog_busy
);
    logic [31:0] busy_cnt_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= prog_busy ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    chk_pull_low_only: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    chk_oe_after_fall: assert property ($rose(sda_oe) |->
        !$past(scl_in, 3) && $past(scl_in, 6))
        else $error("sda pulled low away from scl fall");
    chk_oe_holds: assert property ($rose(sda_oe) |-> sda_oe [*5])
        else $error("sda pull too short");
    chk_busy_no_ack: assert property (prog_busy |-> !sda_oe)
        else $error("sda pulled during programming");
    chk_busy_length: assert property ($fell(prog_busy) |->
        busy_cnt_q <= PROG_CYCLES && busy_cnt_q >= PROG_CYCLES / 2)
        else $error("programming time out of range");
    chk_standby_busy: assert property (prog_busy |-> !standby)
        else $error("standby during programming");
    chk_standby_after: assert property ($fell(prog_busy) |->
        ##[0:4] standby)
        else $error("no standby after programming");
    chk_standby_steady: assert property ($rose(standby) |->
        standby [*3])
        else $error("standby dropped right after rising");
    chk_standby_quiet: assert property (standby |-> !sda_oe)
        else $error("sda pulled in standby");
    cov_ack: cover property ($rose(sda_oe));
    cov_prog: cover property ($fell(prog_busy));
    cov_standby: cover property ($rose(standby));
endmodule
bind serial_eeprom_target serial_eeprom_target_asserts #(
    .PROG_CYCLES(PROG_CYCLES)
) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_bit_hi(chip_select_bit_hi),
    .chip_select_bit_mid(chip_select_bit_mid),
    .chip_select_bit_lo(chip_select_bit_lo),
    .write_lock(write_lock), .standby(standby), .prog_busy(prog_busy)
);
`default_nettype wire

/* serial_bus_host.sv */
// two-wire bus host model with bit, byte, start and stop tasks
// assumes an open-drain wire with pull-up formed by the bench
`timescale 1ns/1ps
`default_nettype none
module serial_bus_host (
    // clock
    input wire logic clk_sys,
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    // scl stands high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // 80 ns bit: sda moves one cycle after scl fall
    task automatic bit_io(input logic b, output logic r);
        cyc(1);
        sda_pull <= ~b;
        cyc(4);
        scl <= 1'b1;
        cyc(3);
        #1 r = sda_wire;
        cyc(2);
        scl <= 1'b0;
    endtask
    task automatic start();
        cyc(1);
        sda_pull <= 1'b0;
        cyc(4);
        scl <= 1'b1;
        cyc(5);
        sda_pull <= 1'b1;
        cyc(5);
        scl <= 1'b0;
    endtask
    task automatic stop();
        cyc(1);
        sda_pull <= 1'b1;
        cyc(4);
        scl <= 1'b1;
        cyc(5);
        sda_pull <= 1'b0;
        cyc(5);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask
endmodule
`default_nettype wire

/* serial_eeprom_target_tb.sv */
// self-checking bench for the serial memory target
// assumes the host model and checker files are compiled beside it
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defs.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
    end end
module serial_eeprom_target_tb;
    import serial_eeprom_pkg::*;
    localparam int PROG = 400;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] straps;
    logic write_lock;
    logic scl, sda_pull, sda_out, sda_oe, standby, prog_busy;
    logic [31:0] cyc_q = 32'h0;
    int bad_count = 0;
    int cmp_count = 0;
    wire sda_wire = ~(sda_pull | sda_oe);
    always #4 clk_sys = ~clk_sys;
    serial_bus_host host (.clk_sys(clk_sys), .scl(scl),
        .sda_pull(sda_pull), .sda_wire(sda_wire));
    serial_eeprom_target #(.PROG_CYCLES(PROG), .FIFO_DEPTH(8)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_bit_hi(straps[2]), .chip_select_bit_mid(straps[1]),
        .chip_select_bit_lo(straps[0]), .write_lock(write_lock),
        .standby(standby), .prog_busy(prog_busy));
    task automatic results();
        $display("tests done: %0d compares, %0d mismatches", cmp_count,
            bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc_q <= cyc_q + 32'h1;
        if (cyc_q == 32'd60000) begin
            bad_count++;
            results();
        end
    end
    task automatic set_ptr(input logic [7:0] ad);
        logic a;
        host.start();
        host.wbyte({`DEV_PREFIX, straps, 1'b0}, a);
        `CHK("dev ack", 1'b1, a)
        `CHK("ack pull", 1'b1, sda_oe)
        `CHK("pad level", 1'b0, sda_out)
        host.wbyte(ad, a);
        `CHK("addr ack", 1'b1, a)
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dat[$]);
        logic a;
        set_ptr(ad);
        foreach (dat[i]) begin
            host.wbyte(dat[i], a);
            `CHK("data ack", 1'b1, a)
        end
        host.stop();
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        // look a little after the edge, once the outputs have settled
        #1;
        while (standby !== 1'b1 && n < PROG + 100) begin
            host.cyc(1);
            #1;
            n++;
        end
        `CHK("standby after prog", 1'b1, standby)
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp[$]);
        logic a;
        logic [7:0] d;
        set_ptr(ad);
        host.start();
        host.wbyte({`DEV_PREFIX, straps, 1'b1}, a);
        `CHK("read ack", 1'b1, a)
        foreach (exp[i]) begin
            host.rbyte(i < exp.size() - 1, d);
            `CHK("read data", exp[i], d)
        end
        host.stop();
        host.cyc(4);
        `CHK("standby after read", 1'b1, standby)
    endtask
    task automatic t_page();
        logic [7:0] q[$];
        logic a;
        for (int i = 0; i < 17; i++) q.push_back(8'h40 + i[7:0]);
        wr(8'h2e, q);
        host.cyc(6);
        `CHK("busy after stop", 1'b1, prog_busy)
        host.start();
        host.wbyte({`DEV_PREFIX, straps, 1'b1}, a);
        `CHK("poll nack", 1'b0, a)
        host.stop();
        wait_done();
        rd_chk(8'h2e, {8'h50, 8'h41, 8'hff});
        rd_chk(8'h20, {8'h42});
        $display("page write test done");
    endtask
    task automatic t_lock();
        write_lock <= 1'b1;
        wr(8'h00, {8'h12});
        host.cyc(8);
        `CHK("locked busy", 1'b0, prog_busy)
        rd_chk(8'h00, {8'hff});
        write_lock <= 1'b0;
        wr(8'h00, {8'h5a});
        wait_done();
        wr(8'h00, {8'ha5});
        wait_done();
        rd_chk(8'hff, {8'hff, 8'ha5});
        $display("write lock test done");
    endtask
    task automatic t_straps();
        logic [2:0] sv[2] = '{3'b101, 3'b010};
        logic [7:0] adr[6] = '{8'ha0, 8'hb4, 8'haa, 8'ha6, 8'ha0, 8'ha4};
        logic exp[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        logic a;
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            if (i % 3 == 0) begin
                straps <= sv[i / 3];
                host.cyc(4);
            end
            host.start();
            host.wbyte(adr[i] | 8'h01, a);
            `CHK("strap ack", exp[i], a)
            if (a === 1'b1) host.rbyte(1'b0, d);
            host.stop();
        end
        straps <= 3'b000;
        host.cyc(4);
        $display("strap test done");
    endtask
    task automatic t_soft();
        logic a;
        logic [7:0] d;
        host.start();
        for (int i = 0; i < 4; i++) host.bit_io(i[0], a);
        host.start();
        for (int i = 0; i < 18; i++) host.bit_io(1'b1, a);
        host.start();
        host.wbyte({`DEV_PREFIX, straps, 1'b1}, a);
        `CHK("ack after soft reset", 1'b1, a)
        host.rbyte(1'b0, d);
        host.stop();
        host.cyc(4);
        `CHK("standby after soft reset", 1'b1, standby)
        $display("soft reset test done");
    endtask
    initial begin
        straps <= 3'h0;
        write_lock <= 1'b0;
        host.cyc(16);
        `CHK("oe in reset", 1'b0, sda_oe)
        `CHK("standby in reset", 1'b1, standby)
        resetn <= 1'b1;
        host.cyc(6);
        `CHK("busy after reset", 1'b0, prog_busy)
        `CHK("standby after reset", 1'b1, standby)
        t_page();
        t_lock();
        t_straps();
        t_soft();
        results();
    end
endmodule
`default_nettype wire
